// ---- ppc_pkg.sv ----
/*
 * constants for the parallel port timing and operation configuration block.
 * assumes a 32-bit classic wishbone slave port, byte address = 4 x index.
 */
package ppc_pkg;
    // register indexes; byte address is four times the index
    localparam logic [31:0] IDX_TIMING = 32'h0c800010;
    localparam logic [31:0] IDX_OPCFG = 32'h0c800012;
    localparam logic [31:0] IDX_XCTL = 32'h0c800015;
    localparam logic [31:0] IDX_OUTR = 32'h0c800016;
    localparam logic [31:0] IDX_INR = 32'h0c800017;
    localparam logic [31:0] IDX_TMRS = 32'h0c800018;
    localparam logic [31:0] IDX_START = 32'h0c800019;
    // timing register fields
    localparam int SETUP_LSB = 0;
    localparam int WIDTH_LSB = 8;
    localparam int TEST_BIT = 15;
    localparam logic [6:0] WIDTH_MIN = 7'h03;
    // operation register fields
    localparam int OP_RSV0 = 0;
    localparam int OP_ONE = 1;
    localparam int OP_IDLE = 3;
    localparam int OP_SOFT_RESET_BIT = 7;
    localparam int OP_ACKOP = 8;
    localparam int OP_BUSYOP = 9;
    localparam int OP_DIAG = 10;
    localparam int OP_ACKBI = 11;
    localparam int OP_BUSYBI = 12;
    localparam int OP_STBBI = 13;
    localparam int OP_FILL = 14;
    localparam int OP_MCLR = 15;
    localparam logic [15:0] OP_RESET = 16'h2000;
    localparam logic [15:0] OP_WMASK = 16'hff81;
    // transfer control fields
    localparam int XC_STB = 0;
    localparam int XC_ACK = 1;
    localparam int XC_BUSY = 2;
    localparam int XC_DIR = 3;
    localparam logic DIR_RESET = 1'b1;
    // pin levels: strobe, acknowledge and busy are active low
    localparam logic STB_IDLE = 1'b1;
    localparam logic ACK_IDLE = 1'b1;
    localparam logic BUSY_ACTIVE = 1'b0;
    typedef enum logic [3:0] {
        PPC_IDLE = 4'h1,
        PPC_SETUP = 4'h2,
        PPC_STROBE = 4'h4,
        PPC_WAIT = 4'h8
    } ppc_state_t;
endpackage : ppc_pkg

// ---- ppc_port_cfg.sv ----
/*
 * timing and operation configuration of a parallel port, with a small
 * strobe sequencer that uses the two programmable timers.
 * assumes a classic wishbone master on the same clock and pins that are
 * synchronous to CLK.
 */
`timescale 1ns/10ps
module ppc_port_cfg
    import ppc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [31:0] ADR_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    output logic ACK_O,
    input wire logic STROBE_PIN_I,
    output logic STROBE_PIN_O,
    output logic STROBE_PIN_OE,
    output logic STROBE_DIR_O,
    input wire logic ACK_PIN_I,
    output logic ACK_PIN_O,
    output logic ACK_PIN_OE,
    output logic ACK_DIR_O,
    input wire logic BUSY_PIN_I,
    output logic BUSY_PIN_O,
    output logic BUSY_PIN_OE,
    output logic BUSY_DIR_O,
    output logic XFER_DIR_O,
    output logic [2:0] CTRL_PINS_O,
    input wire logic [2:0] STATUS_PINS_I,
    output logic STROBE_EVT_O,
    output logic ACK_EVT_O,
    output logic BUSY_EVT_O,
    output logic ACK_HS_EN_O,
    output logic BUSY_HS_EN_O,
    output logic MASTER_WRITE_O,
    output logic MEM_CLEAR_EN_O,
    output logic [7:0] CLEAR_FILL_O
);
    logic [15:0] timing_reg;
    logic [15:0] op_reg;
    logic [3:0] xctl_reg;
    logic [5:0] out_reg;
    logic dir_hold_reg;
    logic diag_d_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [6:0] setup_cnt_reg;
    logic [6:0] width_cnt_reg;
    ppc_state_t state_reg;
    ppc_state_t state_next;
    logic req;
    logic wr;
    logic [31:0] idx;
    logic diag;
    logic soft_reset_bit;
    logic start;
    logic [6:0] width_load;
    logic busy_in;
    logic [15:0] op_rd;
    logic [3:0] xctl_rd;
    logic [2:0] in_rd;
    logic [15:0] wdata;
    logic [15:0] wmask;

    assign req = CYC_I & STB_I & ~ack_reg;
    assign wr = req & WE_I;
    assign idx = {2'b00, ADR_I[31:2]};
    assign diag = op_reg[OP_DIAG];
    assign soft_reset_bit = op_reg[OP_SOFT_RESET_BIT];
    assign wdata = DAT_I[15:0];
    assign wmask = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
    assign start = wr & (idx == IDX_START) & SEL_I[0] & DAT_I[0];

    assign width_load = (timing_reg[WIDTH_LSB +: 7] <= WIDTH_MIN) ?
        WIDTH_MIN : timing_reg[WIDTH_LSB +: 7];

    assign busy_in = diag ? xctl_reg[XC_BUSY] : BUSY_PIN_I;

    // bit 1 forced, idle from sequencer
    always_comb begin
        op_rd = op_reg;
        op_rd[OP_ONE] = 1'b1;
        op_rd[OP_IDLE] = (state_reg == PPC_IDLE);
    end

    // readback from latches in diagnostic mode
    assign xctl_rd = diag ? xctl_reg :
        {xctl_reg[XC_DIR], BUSY_PIN_I, ACK_PIN_I, STROBE_PIN_I};

    assign in_rd = diag ? out_reg[2:0] : STATUS_PINS_I;

    // ------------------------------------------------------------
    // wishbone slave: one-cycle answer, writes at the request edge
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= 32'h00000000;
        end else if (req) begin
            case (idx)
                IDX_TIMING: rdata_reg <= {16'h0000, timing_reg};
                IDX_OPCFG: rdata_reg <= {16'h0000, op_rd};
                IDX_XCTL: rdata_reg <= {28'h0000000, xctl_rd};
                IDX_OUTR: rdata_reg <= {26'h0, out_reg};
                IDX_INR: rdata_reg <= {29'h0, in_rd};
                // buried counters visible only in test
                IDX_TMRS: rdata_reg <= timing_reg[TEST_BIT] ?
                    {17'h0, width_cnt_reg, 1'b0, setup_cnt_reg} :
                    32'h00000000;
                default: rdata_reg <= 32'h00000000;
            endcase
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // setup and width fields, bit 7 reads zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            timing_reg <= 16'h0000;
        end else if (wr && idx == IDX_TIMING) begin
            timing_reg <= (timing_reg & ~wmask) |
                (wdata & wmask & 16'hff7f);
        end
    end

    // reset value, soft reset bit kept until cleared
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_reg <= OP_RESET;
        end else if (wr && idx == IDX_OPCFG) begin
            op_reg <= (op_reg & ~(wmask & OP_WMASK)) |
                (wdata & wmask & OP_WMASK);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            xctl_reg <= {DIR_RESET, 3'h0};
        end else if (wr && idx == IDX_XCTL && SEL_I[0]) begin
            xctl_reg <= DAT_I[3:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            out_reg <= 6'h00;
        end else if (wr && idx == IDX_OUTR && SEL_I[0]) begin
            out_reg <= DAT_I[5:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            diag_d_reg <= 1'b0;
            dir_hold_reg <= DIR_RESET;
        end else begin
            diag_d_reg <= diag;
            if (!diag_d_reg) begin
                dir_hold_reg <= xctl_reg[XC_DIR];
            end
        end
    end

    // ------------------------------------------------------------
    // strobe sequencer and timers
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PPC_IDLE: begin
                if (start && !xctl_reg[XC_DIR]) begin
                    state_next = PPC_SETUP;
                end
            end
            // expiry when the count has run out
            PPC_SETUP: begin
                if (setup_cnt_reg == 7'h00) begin
                    state_next = PPC_STROBE;
                end
            end
            PPC_STROBE: begin
                if (width_cnt_reg == 7'h00) begin
                    state_next = PPC_WAIT;
                end
            end
            PPC_WAIT: begin
                if (!op_reg[OP_BUSYOP] || busy_in != BUSY_ACTIVE) begin
                    state_next = PPC_IDLE;
                end
            end
            default: state_next = PPC_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= PPC_IDLE;
        end else if (soft_reset_bit) begin
            state_reg <= PPC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // load at interval start, count down each clock
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            setup_cnt_reg <= 7'h00;
            width_cnt_reg <= 7'h00;
        end else if (soft_reset_bit) begin
            setup_cnt_reg <= 7'h00;
            width_cnt_reg <= 7'h00;
        end else begin
            if (state_reg == PPC_IDLE && state_next == PPC_SETUP) begin
                setup_cnt_reg <= timing_reg[SETUP_LSB +: 7];
            end else if (setup_cnt_reg != 7'h00) begin
                setup_cnt_reg <= setup_cnt_reg - 7'h01;
            end
            if (state_reg == PPC_SETUP && state_next == PPC_STROBE) begin
                width_cnt_reg <= width_load;
            end else if (width_cnt_reg != 7'h00) begin
                width_cnt_reg <= width_cnt_reg - 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            STROBE_PIN_O <= STB_IDLE;
            STROBE_PIN_OE <= 1'b0;
            STROBE_DIR_O <= 1'b0;
            ACK_PIN_O <= ACK_IDLE;
            ACK_PIN_OE <= 1'b0;
            ACK_DIR_O <= 1'b0;
            BUSY_PIN_O <= 1'b0;
            BUSY_PIN_OE <= 1'b0;
            BUSY_DIR_O <= 1'b0;
            XFER_DIR_O <= DIR_RESET;
        end else begin
            // strobe output unless bidir and reading
            STROBE_PIN_OE <= ~op_reg[OP_STBBI] | ~xctl_reg[XC_DIR];
            STROBE_DIR_O <= ~op_reg[OP_STBBI] | ~xctl_reg[XC_DIR];
            // acknowledge output when bidir and reading
            ACK_PIN_OE <= op_reg[OP_ACKBI] & xctl_reg[XC_DIR];
            ACK_DIR_O <= op_reg[OP_ACKBI] & xctl_reg[XC_DIR];
            // busy output when bidir and reading
            BUSY_PIN_OE <= op_reg[OP_BUSYBI] & xctl_reg[XC_DIR];
            BUSY_DIR_O <= op_reg[OP_BUSYBI] & xctl_reg[XC_DIR];
            // inactive strobe and ack in diagnostic mode
            if (diag) begin
                STROBE_PIN_O <= STB_IDLE;
                ACK_PIN_O <= ACK_IDLE;
            end else begin
                STROBE_PIN_O <= (state_reg == PPC_STROBE) ? ~STB_IDLE :
                    xctl_reg[XC_STB];
                ACK_PIN_O <= xctl_reg[XC_ACK];
            end
            BUSY_PIN_O <= diag ? BUSY_ACTIVE : xctl_reg[XC_BUSY];
            XFER_DIR_O <= diag ? dir_hold_reg : xctl_reg[XC_DIR];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CTRL_PINS_O <= 3'h0;
            STROBE_EVT_O <= 1'b0;
            ACK_EVT_O <= 1'b0;
            BUSY_EVT_O <= 1'b0;
        end else begin
            // control pins held low in diagnostic mode
            CTRL_PINS_O <= diag ? 3'h0 : out_reg[2:0];
            // interrupt sources from latches or pins
            STROBE_EVT_O <= diag ? xctl_reg[XC_STB] : STROBE_PIN_I;
            ACK_EVT_O <= diag ? xctl_reg[XC_ACK] : ACK_PIN_I;
            BUSY_EVT_O <= busy_in;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ACK_HS_EN_O <= 1'b0;
            BUSY_HS_EN_O <= 1'b0;
            MASTER_WRITE_O <= 1'b1;
            MEM_CLEAR_EN_O <= 1'b0;
            CLEAR_FILL_O <= 8'h00;
        end else begin
            ACK_HS_EN_O <= op_reg[OP_ACKOP];
            BUSY_HS_EN_O <= op_reg[OP_BUSYOP];
            MASTER_WRITE_O <= op_reg[OP_STBBI];
            MEM_CLEAR_EN_O <= op_reg[OP_MCLR];
            CLEAR_FILL_O <= {8{op_reg[OP_FILL]}};
        end
    end

    assign ACK_O = ack_reg;
    assign DAT_O = rdata_reg;
endmodule : ppc_port_cfg

// ---- ppc_cfg_props.sv ----
/*
 assertions on the port configuration block, kept against shadow copies
 of the registers; assumes a bind to ppc_port_cfg.
*/
`timescale 1ns/10ps
module ppc_cfg_props
    import ppc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [31:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic ACK_O,
    input wire logic STROBE_PIN_O,
    input wire logic STROBE_PIN_OE,
    input wire logic STROBE_DIR_O,
    input wire logic ACK_PIN_OE,
    input wire logic ACK_DIR_O,
    input wire logic BUSY_PIN_O,
    input wire logic BUSY_PIN_OE,
    input wire logic BUSY_DIR_O,
    input wire logic XFER_DIR_O,
    input wire logic ACK_HS_EN_O,
    input wire logic BUSY_HS_EN_O,
    input wire logic MASTER_WRITE_O,
    input wire logic MEM_CLEAR_EN_O,
    input wire logic [7:0] CLEAR_FILL_O
);
    logic [15:0] op_reg;
    logic [15:0] m;
    logic dir_reg;
    logic diag_d;
    logic wr;
    logic quiet;
    assign wr = CYC_I && STB_I && !ACK_O && WE_I;
    assign m = OP_WMASK & {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
    // no diagnostic mode in this or the previous cycle
    assign quiet = !op_reg[OP_DIAG] && !diag_d;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_reg <= OP_RESET;
        end else if (wr && ADR_I[31:2] == IDX_OPCFG[29:0]) begin
            op_reg <= (op_reg & ~m) | (DAT_I[15:0] & m);
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dir_reg <= DIR_RESET;
        end else if (wr && SEL_I[0] && ADR_I[31:2] == IDX_XCTL[29:0]) begin
            dir_reg <= DAT_I[XC_DIR];
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            diag_d <= 1'b0;
        end else begin
            diag_d <= op_reg[OP_DIAG];
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_diag;
        op_reg[OP_DIAG] ##1 op_reg[OP_DIAG];
    endsequence
    property p_fill; CLEAR_FILL_O == {8{$past(op_reg[OP_FILL])}}; endproperty
    a_fill: assert property (p_fill)
        else $error("clear fill wrong");
    property p_mclr; MEM_CLEAR_EN_O == $past(op_reg[OP_MCLR]); endproperty
    a_mclr: assert property (p_mclr)
        else $error("clear enable wrong");
    property p_hs;
        {BUSY_HS_EN_O, ACK_HS_EN_O} == $past(op_reg[OP_BUSYOP:OP_ACKOP]);
    endproperty
    a_hs: assert property (p_hs)
        else $error("handshake enables wrong");
    property p_proto; MASTER_WRITE_O == $past(op_reg[OP_STBBI]); endproperty
    a_proto: assert property (p_proto)
        else $error("protocol select wrong");
    property p_ackdir;
        $past(quiet) |-> ACK_PIN_OE == ($past(op_reg[OP_ACKBI]) &&
            $past(dir_reg)) && ACK_DIR_O == ACK_PIN_OE;
    endproperty
    a_ackdir: assert property (p_ackdir)
        else $error("ack direction wrong");
    property p_busydir;
        $past(quiet) |-> BUSY_PIN_OE == ($past(op_reg[OP_BUSYBI]) &&
            $past(dir_reg)) && BUSY_DIR_O == BUSY_PIN_OE;
    endproperty
    a_busydir: assert property (p_busydir)
        else $error("busy direction wrong");
    property p_stbdir;
        $past(quiet) |-> STROBE_PIN_OE == !($past(op_reg[OP_STBBI]) &&
            $past(dir_reg)) && STROBE_DIR_O == STROBE_PIN_OE;
    endproperty
    a_stbdir: assert property (p_stbdir)
        else $error("strobe direction wrong");
    property p_dstb; s_diag |=> !STROBE_PIN_OE || STROBE_PIN_O == STB_IDLE;
    endproperty
    a_dstb: assert property (p_dstb)
        else $error("strobe not idle in diagnostics");
    property p_dbusy;
        s_diag |=> BUSY_PIN_O == BUSY_ACTIVE && $stable(XFER_DIR_O);
    endproperty
    a_dbusy: assert property (p_dbusy)
        else $error("busy or direction wrong in diagnostics");
endmodule : ppc_cfg_props
bind ppc_port_cfg ppc_cfg_props i_props (.CLK(CLK), .RST(RST),
    .ADR_I(ADR_I), .DAT_I(DAT_I), .WE_I(WE_I), .SEL_I(SEL_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .STROBE_PIN_O(STROBE_PIN_O), .STROBE_PIN_OE(STROBE_PIN_OE),
    .STROBE_DIR_O(STROBE_DIR_O), .ACK_PIN_OE(ACK_PIN_OE),
    .ACK_DIR_O(ACK_DIR_O), .BUSY_PIN_O(BUSY_PIN_O),
    .BUSY_PIN_OE(BUSY_PIN_OE), .BUSY_DIR_O(BUSY_DIR_O),
    .XFER_DIR_O(XFER_DIR_O), .ACK_HS_EN_O(ACK_HS_EN_O),
    .BUSY_HS_EN_O(BUSY_HS_EN_O), .MASTER_WRITE_O(MASTER_WRITE_O),
    .MEM_CLEAR_EN_O(MEM_CLEAR_EN_O), .CLEAR_FILL_O(CLEAR_FILL_O));

// ---- ppc_printer.sv ----
/*
 printer model: answers a strobe with busy and an acknowledge pulse.
 assumes active-low strobe, busy and ack lines.
*/
`timescale 1ns/10ps
module ppc_printer (
    input wire logic clk,
    input wire logic rst,
    input wire logic strobe_n,
    input wire logic slow,
    output logic busy_n,
    output logic ack_n,
    output logic [2:0] status
);
    logic [3:0] cnt_reg;
    assign status = 3'h2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            busy_n <= 1'b1;
            ack_n <= 1'b1;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            busy_n <= (cnt_reg == 4'h1);
            ack_n <= (cnt_reg != 4'h2);
        end else if (!strobe_n) begin
            cnt_reg <= slow ? 4'hc : 4'h3;
            busy_n <= 1'b0;
        end
    end
endmodule : ppc_printer

// ---- tb_top.sv ----
/*
 bench for the port configuration block and the printer model.
 assumes ppc_pkg, the design and the bound checker.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
    import ppc_pkg::*;
;
    logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, slow = 0;
    logic [31:0] adr = '0, wdat = '0, rdat;
    logic [3:0] sel = '0;
    logic ack, s_o, s_oe, a_o, a_oe, b_o, b_oe, pa_n, pb_n, xdir, se, ae, be;
    logic [2:0] ctrl, st;
    logic [15:0] q, seed;
    logic [6:0] sv[4] = '{7'h00, 7'h09, 7'h7f, 7'h28};
    logic [6:0] wv[4] = '{7'h02, 7'h03, 7'h0a, 7'h7f};
    int n_errors = 0, tests_run = 0, t, w, k;
    always #12.5 clk = ~clk;
    ppc_port_cfg i_dut (.CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(wdat),
        .DAT_O(rdat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb),
        .ACK_O(ack), .STROBE_PIN_I(s_oe ? s_o : 1'b1), .STROBE_PIN_O(s_o),
        .STROBE_PIN_OE(s_oe), .STROBE_DIR_O(), .ACK_PIN_O(a_o),
        .ACK_PIN_I(a_oe ? a_o : pa_n), .ACK_PIN_OE(a_oe), .ACK_DIR_O(),
        .BUSY_PIN_I(b_oe ? b_o : pb_n), .BUSY_PIN_O(b_o), .BUSY_PIN_OE(b_oe),
        .BUSY_DIR_O(), .XFER_DIR_O(xdir), .CTRL_PINS_O(ctrl),
        .STATUS_PINS_I(st), .STROBE_EVT_O(se), .ACK_EVT_O(ae),
        .BUSY_EVT_O(be), .ACK_HS_EN_O(), .BUSY_HS_EN_O(),
        .MASTER_WRITE_O(), .MEM_CLEAR_EN_O(), .CLEAR_FILL_O());
    ppc_printer i_prn (.clk(clk), .rst(rst), .strobe_n(s_oe ? s_o : 1'b1),
        .slow(slow), .busy_n(pb_n), .ack_n(pa_n), .status(st));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // setup entry one edge after start, pin register adds one more
    function automatic int exp_s(input logic [6:0] d);
        return d + 2;
    endfunction : exp_s
    function automatic int exp_w(input logic [6:0] d);
        return (d <= WIDTH_MIN) ? 4 : d + 1;
    endfunction : exp_w
    task automatic bus(input logic [31:0] idx, input logic wen,
            input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= {idx[29:0], 2'b00};
        wdat <= {16'h0000, d};
        we <= wen;
        sel <= 4'h3;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) n_errors++;
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (10000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        seed = 16'h0049;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(IDX_OPCFG, 0, 0);
        `CHK("opcfg reset", 16'h200a, q)
        bus(IDX_XCTL, 0, 0);
        `CHK("dir reset", 2'h3, {xdir, q[XC_DIR]})
        bus(IDX_START + 32'h1, 0, 0);
        `CHK("unmapped", 16'h0000, q)
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            bus(IDX_TIMING, 1, seed);
            bus(IDX_TIMING, 0, 0);
            `CHK("timing", seed & 16'hff7f, q)
            bus(IDX_XCTL, 1, seed ^ 16'h5a5a);
            bus(IDX_OPCFG, 1, ~seed);
            bus(IDX_OPCFG, 0, 0);
            `CHK("opcfg", (~seed & OP_WMASK) | 16'h000a, q)
        end
        bus(IDX_XCTL, 1, 16'h0008);
        bus(IDX_OPCFG, 1, 16'h0400);
        bus(IDX_OUTR, 1, 16'h0005);
        bus(IDX_INR, 0, 0);
        `CHK("loopback", 6'h05, {ctrl, q[2:0]})
        bus(IDX_XCTL, 1, 16'h0005);
        repeat (2) @(posedge clk);
        `CHK("latch events", 3'h5, {be, ae, se})
        bus(IDX_XCTL, 0, 0);
        `CHK("latch read", 4'hd, {xdir, q[2:0]})
        bus(IDX_OPCFG, 1, 16'h0000);
        bus(IDX_INR, 0, 0);
        `CHK("status pins", 9'h0aa, {a_o, b_o, xdir, ctrl, q[2:0]})
        for (int i = 0; i < 4; i++) begin
            bus(IDX_OPCFG, 1, i[0] ? 16'h0200 : 16'h0000);
            slow <= i[1];
            bus(IDX_TIMING, 1, {1'b0, wv[i], 1'b0, sv[i]});
            bus(IDX_START, 1, 16'h0001);
            for (t = 0; s_o !== 1'b0 && t < 400; t++) @(posedge clk);
            for (w = 0; s_o === 1'b0 && w < 200; w++) @(posedge clk);
            `CHK("setup", exp_s(sv[i]), t)
            `CHK("width", exp_w(wv[i]), w)
            k = 0;
            do begin
                bus(IDX_OPCFG, 0, 0);
                k++;
            end while (q[OP_IDLE] !== 1'b1 && k < 40);
            `CHK("idle", 1'b1, q[OP_IDLE])
        end
        bus(IDX_TIMING, 1, 16'h0564);
        bus(IDX_START, 1, 16'h0001);
        bus(IDX_OPCFG, 0, 0);
        `CHK("busy flag", 1'b0, q[OP_IDLE])
        bus(IDX_TMRS, 0, 0);
        `CHK("counters hidden", 16'h0000, q)
        bus(IDX_TIMING, 1, 16'h8564);
        bus(IDX_TMRS, 0, 0);
        `CHK("counters shown", 1'b1, q[6:0] != 7'h00)
        bus(IDX_OPCFG, 1, 16'h0080);
        bus(IDX_OPCFG, 0, 0);
        `CHK("soft reset", 16'h008a, q)
        bus(IDX_TMRS, 0, 0);
        `CHK("timers cleared", 16'h0000, q)
        for (t = 0; t < 120 && s_o !== 1'b0; t++) @(posedge clk);
        `CHK("no strobe", 120, t)
        bus(IDX_TIMING, 0, 0);
        `CHK("regs kept", 16'h8564, q)
        give_verdict();
    end
endmodule : tb_top
